// >>> hw/astc_pkg.sv
/*
 * Package for the converter sample timing block: register offsets,
 * field positions, reset values, time tables and the step record.
 * Assumes a 200 MHz device clock.
 */
package astc_pkg;

	localparam int unsigned CLK_NS  = 5;
	localparam int unsigned TICK_NS = 10;
	localparam int unsigned CNT_W   = 17;

	// Register offsets
	localparam logic [7:0] OFS_DELAY  = 8'h3D;
	localparam logic [7:0] OFS_CELL   = 8'h3E;
	localparam logic [7:0] OFS_AUX    = 8'h3F;
	localparam logic [7:0] OFS_OVS    = 8'h60;
	localparam logic [7:0] OFS_STATUS = 8'h61;

	// Field positions
	localparam int unsigned POS_CELL_DLY = 4;
	localparam int unsigned POS_AUX_DLY  = 0;
	localparam int unsigned POS_CELL_IVL = 4;
	localparam int unsigned POS_DIE_IVL  = 0;
	localparam logic [7:0]  DELAY_WMASK  = 8'h77;

	// Reset values
	localparam logic [7:0]  RST_DELAY = 8'h00;
	localparam logic [7:0]  RST_CELL  = 8'h44;
	localparam logic [31:0] RST_AUX   = 32'h44444444;
	localparam logic [2:0]  RST_OVS   = 3'h0;
	localparam logic [2:0]  OVS_MAX   = 3'h5;

	// Settling delays and sample intervals in ns
	localparam int unsigned DLY_NS [8] = '{0, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
	localparam int unsigned IVL_NS [16] = '{4130, 5960, 8020, 10000, 12600, 14900, 17400, 19900,
		24900, 30000, 40100, 60000, 100000, 200000, 500000, 1000000};
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;

	localparam logic [1:0] KIND_CELL = 2'h0;
	localparam logic [1:0] KIND_DIE  = 2'h1;
	localparam logic [1:0] KIND_AUX  = 2'h2;

	typedef struct packed {
		logic       first;
		logic [1:0] kind;
		logic [2:0] aux_idx;
	} astc_step_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_SETTLE = 3'b010,
		ST_WAIT   = 3'b100
	} astc_state_t;

	function automatic logic [CNT_W-1:0] dly_ticks(input logic [2:0] code);
		dly_ticks = CNT_W'(DLY_NS[code] / TICK_NS);
	endfunction : dly_ticks

	function automatic logic [CNT_W-1:0] ivl_ticks(input logic [3:0] code);
		ivl_ticks = CNT_W'(IVL_NS[code] / TICK_NS);
	endfunction : ivl_ticks

endpackage : astc_pkg

// >>> hw/astc_timing.sv
/*
 * Sample timing configuration and pacing for the converter sequencer.
 * Assumes the sequencer offers one channel step at a time and waits for
 * the done pulse; register port is a plain strobe port on the same clock.
 */
// The plain strobed port was left to the implementer.
// Contract
// - cell settle delay code picks none to 200us
// - settle once per request, not per oversample
// - aux settle delay uses the same codes
// - reserved delay bits read zero, write zero
// - later channels use only their interval
// - upper cell nibble sets cell voltage interval
// - lower cell nibble sets die temperature interval
// - interval codes map 4.13us to 1000us
// - aux register holds eight codes, input0 on top
// - oversample code gives 1 to 32 samples
`timescale 1ns/10ps
`default_nettype none

module astc_timing #(
	parameter int unsigned TIME_DIV = 1
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	// Sequencer steps
	input  wire logic                step_valid,
	input  wire astc_pkg::astc_step_t step_in,
	output logic                     step_ready,
	output logic                     sample_now,
	output logic                     step_done,
	output logic [2:0]               ovs_code
);
	import astc_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]  delay_q;
	logic [7:0]  cell_q;
	logic [31:0] aux_q;
	logic [2:0]  ovs_q;
	logic [31:0] rdata_q;

	wire wr_delay = reg_wr && (reg_addr == OFS_DELAY);
	wire wr_cell  = reg_wr && (reg_addr == OFS_CELL);
	wire wr_aux   = reg_wr && (reg_addr == OFS_AUX);
	wire wr_ovs   = reg_wr && (reg_addr == OFS_OVS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			delay_q <= RST_DELAY;
			cell_q  <= RST_CELL;
			aux_q   <= RST_AUX;
			ovs_q   <= RST_OVS;
		end else begin
			// Reserved bits never stored, so they always read zero
			if (wr_delay) delay_q <= reg_wdata[7:0] & DELAY_WMASK;
			if (wr_cell)  cell_q  <= reg_wdata[7:0];
			if (wr_aux)   aux_q   <= reg_wdata;
			if (wr_ovs)   ovs_q   <= reg_wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Field decode

	wire [2:0] cell_dly_code = delay_q[POS_CELL_DLY +: 3];
	wire [2:0] aux_dly_code  = delay_q[POS_AUX_DLY +: 3];
	wire [3:0] cell_ivl_code = cell_q[POS_CELL_IVL +: 4];
	wire [3:0] die_ivl_code  = cell_q[POS_DIE_IVL +: 4];
	// Input 0 sits in the top nibble
	wire [4:0] aux_pos       = 5'(4 * (7 - int'(step_in.aux_idx)));
	wire [3:0] aux_ivl_code  = aux_q[aux_pos +: 4];

	// Reserved oversample codes fall back to a single sample
	wire [2:0] ovs_eff = (ovs_q > OVS_MAX) ? 3'h0 : ovs_q;
	wire [5:0] samples = 6'(1 << ovs_eff);

	function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] t);
		logic [CNT_W-1:0] s;
		s = CNT_W'(t / TIME_DIV);
		scale = (s == '0) ? CNT_W'(1) : s;
	endfunction : scale

	wire [3:0] step_ivl_code =
		(step_in.kind == KIND_CELL) ? cell_ivl_code :
		(step_in.kind == KIND_DIE)  ? die_ivl_code  : aux_ivl_code;
	wire [2:0] step_dly_code = (step_in.kind == KIND_AUX) ? aux_dly_code : cell_dly_code;
	wire [CNT_W-1:0] step_ivl = scale(ivl_ticks(step_ivl_code));
	wire [CNT_W-1:0] step_dly = scale(dly_ticks(step_dly_code));

	////////////////////////////////////////////////////////////////////
	// Timebase

	logic [3:0] tb_q;
	wire        tick = (tb_q == 4'(TICK_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) tb_q <= 4'h0;
		else tb_q <= tick ? 4'h0 : tb_q + 4'h1;
	end

	////////////////////////////////////////////////////////////////////
	// Step pacing

	astc_state_t      st_q, st_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] ivl_q, ivl_d;
	logic [5:0]       left_q, left_d;
	logic             sample_q, sample_d;
	logic             done_q, done_d;

	wire accept  = step_valid && (st_q == ST_IDLE);
	wire expire  = tick && (cnt_q <= CNT_W'(1));
	// A settle only belongs to the first channel of a request
	wire settle  = step_in.first && (step_dly_code != 3'h0);

	always_comb begin
		st_d     = st_q;
		cnt_d    = (tick && cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
		ivl_d    = ivl_q;
		left_d   = left_q;
		sample_d = 1'b0;
		done_d   = 1'b0;
		case (st_q)
			ST_IDLE: begin
				if (accept) begin
					ivl_d  = step_ivl;
					left_d = samples - 6'h1;
					if (settle) begin
						st_d  = ST_SETTLE;
						cnt_d = step_dly;
					end else begin
						st_d  = ST_WAIT;
						cnt_d = step_ivl;
					end
				end
			end
			ST_SETTLE: begin
				if (expire) begin
					st_d  = ST_WAIT;
					cnt_d = ivl_q;
				end
			end
			ST_WAIT: begin
				if (expire) begin
					sample_d = 1'b1;
					if (left_q == 6'h0) begin
						st_d   = ST_IDLE;
						done_d = 1'b1;
					end else begin
						// Extra oversamples reuse the interval only
						left_d = left_q - 6'h1;
						cnt_d  = ivl_q;
					end
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= ST_IDLE;
			cnt_q    <= '0;
			ivl_q    <= '0;
			left_q   <= 6'h0;
			sample_q <= 1'b0;
			done_q   <= 1'b0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			ivl_q    <= ivl_d;
			left_q   <= left_d;
			sample_q <= sample_d;
			done_q   <= done_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path

	wire [31:0] status = {23'h0, left_q, st_q};
	wire [31:0] rd_mux =
		(reg_addr == OFS_DELAY)  ? {24'h0, delay_q} :
		(reg_addr == OFS_CELL)   ? {24'h0, cell_q}  :
		(reg_addr == OFS_AUX)    ? aux_q            :
		(reg_addr == OFS_OVS)    ? {29'h0, ovs_q}   :
		(reg_addr == OFS_STATUS) ? status           : 32'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rdata_q <= 32'h0;
		else rdata_q <= reg_rd ? rd_mux : 32'h0;
	end

	assign reg_rdata  = rdata_q;
	assign step_ready = (st_q == ST_IDLE);
	assign sample_now = sample_q;
	assign step_done  = done_q;
	assign ovs_code   = ovs_eff;

	////////////////////////////////////////////////////////////////////
	// Checks

	rsvd_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == OFS_DELAY |=> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
		else $error("reserved delay bit read nonzero");

	settle_first_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q != ST_SETTLE ##1 st_q == ST_SETTLE |-> $past(accept) && $past(step_in.first))
		else $error("settle entered without first channel");

	no_settle_repeat_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_WAIT |=> st_q != ST_SETTLE)
		else $error("settle repeated after sampling began");

	cell_delay_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.first && step_in.kind == KIND_CELL && cell_dly_code != 3'h0
		|=> st_q == ST_SETTLE && cnt_q == scale(dly_ticks($past(cell_dly_code))))
		else $error("cell settle delay load wrong");

	aux_delay_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.first && step_in.kind == KIND_AUX && aux_dly_code != 3'h0
		|=> st_q == ST_SETTLE && cnt_q == scale(dly_ticks($past(aux_dly_code))))
		else $error("aux settle delay load wrong");

	cell_ivl_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.kind == KIND_CELL |=> ivl_q == scale(ivl_ticks($past(cell_q[7:4]))))
		else $error("cell interval not from upper nibble");

	die_ivl_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.kind == KIND_DIE |=> ivl_q == scale(ivl_ticks($past(cell_q[3:0]))))
		else $error("die interval not from lower nibble");

	aux0_ivl_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.kind == KIND_AUX && step_in.aux_idx == 3'h0
		|=> ivl_q == scale(ivl_ticks($past(aux_q[31:28]))))
		else $error("aux input 0 interval not from top nibble");

	ovs_count_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && ovs_q == 3'h3 |=> left_q == 6'h7)
		else $error("oversample count wrong");

	sample_done_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
		step_done |-> sample_now && st_q == ST_IDLE)
		else $error("done without final sample");

	tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
		tick |=> !tick)
		else $error("timebase tick too frequent");

	tick_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		tb_q <= 4'(TICK_CYCLES - 1))
		else $error("timebase divider out of range");

	// Read data must not linger, or a stale word could pass for a fresh read
	rdata_idle_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data stands without a read");

	delay_rsvd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(delay_q & ~DELAY_WMASK) == 8'h00)
		else $error("reserved delay bit stored");

	no_delay_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.first && step_dly_code == 3'h0 |=> st_q == ST_WAIT)
		else $error("settle entered with delay code zero");

	later_ivl_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && !step_in.first |=> st_q == ST_WAIT && cnt_q == ivl_q)
		else $error("later channel not paced by interval only");

	settle_to_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_SETTLE && expire |=> st_q == ST_WAIT && cnt_q == ivl_q)
		else $error("settle not followed by the interval");

	ovs_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_q == ST_WAIT && expire && left_q != 6'h0 |=> st_q == ST_WAIT && cnt_q == ivl_q)
		else $error("oversample did not reload the interval");

	aux7_ivl_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		accept && step_in.kind == KIND_AUX && step_in.aux_idx == 3'h7
		|=> ivl_q == scale(ivl_ticks($past(aux_q[3:0]))))
		else $error("aux input 7 interval not from bottom nibble");

	ovs_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
		ovs_q > OVS_MAX |-> ovs_code == 3'h0)
		else $error("reserved oversample code not single sample");

	sample_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		sample_now |=> !sample_now)
		else $error("sample pulse longer than one cycle");

endmodule : astc_timing

`default_nettype wire

// >>> test/astc_seq_model.sv
/*
 * Model of the converter sequencer that sits behind the timing block.
 * Assumes the bench pulses go for one cycle and waits while busy is high.
 */
`timescale 1ns/10ps
`default_nettype none

module astc_seq_model
	import astc_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// Bench command
	input  wire logic                 go,
	input  wire astc_pkg::astc_step_t go_step,
	output logic                      busy,
	output logic [15:0]               cycles,
	output logic [7:0]                samples,
	// Step port
	output logic                      step_valid,
	output astc_pkg::astc_step_t      step_in,
	input  wire logic                 step_ready,
	input  wire logic                 sample_now,
	input  wire logic                 step_done
);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_valid <= 1'b0;
			step_in    <= '0;
			busy       <= 1'b0;
			cycles     <= '0;
			samples    <= '0;
		end else if (go) begin
			step_valid <= 1'b1;
			step_in    <= go_step;
			busy       <= 1'b1;
			cycles     <= '0;
			samples    <= '0;
		end else if (step_valid && step_ready) begin
			step_valid <= 1'b0;
			// Released step bus must not keep showing the accepted value
			step_in    <= ~step_in;
		end else if (busy) begin
			cycles  <= cycles + 16'h1;
			samples <= samples + 8'(sample_now);
			if (step_done) begin
				busy <= 1'b0;
			end
		end
	end

endmodule : astc_seq_model

`default_nettype wire

// >>> test/tb_top.sv
/*
 * Register and pacing tests for the sample timing block.
 * Assumes the sequencer model beside it and a shortened time divider.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import astc_pkg::*;

	localparam int unsigned DIV = 100;

	logic        clk, rst_n, reg_wr, reg_rd, go, step_valid, step_ready;
	logic        sample_now, step_done, busy;
	logic [7:0]  reg_addr, samples;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0]  ovs_code;
	logic [15:0] cycles;
	astc_step_t  go_step, step_in;
	int          errors, n_tests;

	astc_timing #(.TIME_DIV(DIV)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .step_valid(step_valid), .step_in(step_in),
		.step_ready(step_ready), .sample_now(sample_now), .step_done(step_done), .ovs_code(ovs_code));

	astc_seq_model seq_u (.clk(clk), .rst_n(rst_n), .go(go), .go_step(go_step), .busy(busy), .cycles(cycles),
		.samples(samples), .step_valid(step_valid), .step_in(step_in), .step_ready(step_ready),
		.sample_now(sample_now), .step_done(step_done));

	////////////////////////////////////////////////////////////////////////
	function automatic int ti(input int c);
		return IVL_NS[c] / TICK_NS / DIV;
	endfunction : ti

	function automatic int td(input int c);
		return DLY_NS[c] / TICK_NS / DIV;
	endfunction : td

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(what, exp, reg_rdata);
		@(posedge clk);
	endtask : rd

	// Tolerance grows with the sample count: tick phase is free-running
	task automatic run_step(input logic f, input logic [1:0] k, input logic [2:0] ix, input int exp, input int n);
		int guard;
		go_step <= '{first: f, kind: k, aux_idx: ix};
		go      <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		guard = 0;
		while (busy === 1'b1 && guard < 20000) begin
			@(posedge clk);
			guard++;
		end
		check("step_guard", 32'h0, 32'(guard >= 20000));
		check("step_cycles", 32'h1, 32'(int'(cycles) >= exp - n - 1 && int'(cycles) <= exp + n + 1));
		check("step_samples", 32'(n), 32'(samples));
	endtask : run_step

	task automatic tally_and_finish;
		if (errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		tally_and_finish();
	end

	initial begin
		{rst_n, reg_wr, reg_rd, go} = '0;
		reg_addr  = '0;
		reg_wdata = '0;
		go_step   = '0;
		errors    = 0;
		n_tests   = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(OFS_DELAY, 32'h00, "delay_reset");
		rd(OFS_CELL, 32'h44, "cell_reset");
		rd(OFS_AUX, 32'h44444444, "aux_reset");
		rd(OFS_STATUS, 32'h1, "status_idle");
		wr(OFS_DELAY, 32'hFF);
		rd(OFS_DELAY, 32'h77, "delay_reserved");
		wr(8'h10, 32'hFF);
		rd(8'h10, 32'h00, "unmapped");
		wr(OFS_DELAY, 32'h31);
		wr(OFS_CELL, 32'hA5);
		wr(OFS_AUX, 32'h01234567);
		rd(OFS_CELL, 32'hA5, "cell_ivl");
		rd(OFS_AUX, 32'h01234567, "aux_ivl");
		for (int c = 0; c < 8; c++) begin
			wr(OFS_OVS, 32'(c));
			check("ovs_code", (c > 5) ? 32'h0 : 32'(c), 32'(ovs_code));
		end
		wr(OFS_OVS, 32'h0);
		run_step(1'b1, KIND_CELL, 3'h0, 2 * (td(3) + ti(10)), 1);
		run_step(1'b0, KIND_CELL, 3'h0, 2 * ti(10), 1);
		run_step(1'b0, KIND_DIE, 3'h0, 2 * ti(5), 1);
		run_step(1'b1, KIND_AUX, 3'h7, 2 * (td(1) + ti(7)), 1);
		for (int i = 0; i < 8; i++) begin
			run_step(1'b0, KIND_AUX, 3'(i), 2 * ti(i), 1);
		end
		wr(OFS_OVS, 32'h2);
		run_step(1'b1, KIND_CELL, 3'h0, 2 * (td(3) + 4 * ti(10)), 4);
		wr(OFS_OVS, 32'h3);
		run_step(1'b0, KIND_CELL, 3'h0, 2 * 8 * ti(10), 8);
		wr(OFS_OVS, 32'h0);
		wr(OFS_DELAY, 32'h00);
		for (int c = 0; c < 16; c++) begin
			wr(OFS_CELL, 32'({4'(c), 4'h5}));
			run_step(1'b1, KIND_CELL, 3'h0, 2 * ti(c), 1);
		end
		tally_and_finish();
	end

endmodule : tb_top

`default_nettype wire
